// ===== pcc_params.svh
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// Clock and timing
`define PCC_CLK_PERIOD_NS 100
`define PCC_STEP_TIME_NS 2730000
// Arbitrary default; set the real pulse width per product
`define PCC_LED_ON_NS 10000
`define PCC_WAIT_LONG_FACTOR 12
`define PCC_FULL_STEPS 9'h100

// Register offsets
`define PCC_OFF_FUNCTION_ENABLE 5'h00
`define PCC_OFF_INTEGRATION_TIME 5'h02
`define PCC_OFF_WAIT_TIME 5'h03
`define PCC_OFF_LOW_THRESHOLD_LO 5'h08
`define PCC_OFF_LOW_THRESHOLD_HI 5'h09
`define PCC_OFF_HIGH_THRESHOLD_LO 5'h0A
`define PCC_OFF_HIGH_THRESHOLD_HI 5'h0B
`define PCC_OFF_IRQ_PERSISTENCE 5'h0C
`define PCC_OFF_WAIT_DRIVE_OPTIONS 5'h0D
`define PCC_OFF_LED_PULSE_COUNT 5'h0E

// Reset values
`define PCC_RST_FUNCTION_ENABLE 8'h00
`define PCC_RST_INTEGRATION_TIME 8'hFF
`define PCC_RST_WAIT_TIME 8'hFF
`define PCC_RST_THRESHOLD 8'h00
`define PCC_RST_IRQ_PERSISTENCE 8'h00
`define PCC_RST_WAIT_DRIVE_OPTIONS 8'h00
`define PCC_RST_LED_PULSE_COUNT 8'h00

// Field positions
`define PCC_BIT_OSCILLATOR_ON 0
`define PCC_BIT_PROX_FUNCTION_ENABLE 2
`define PCC_BIT_WAIT_ENABLE 3
`define PCC_BIT_PROX_IRQ_ENABLE 5
`define PCC_BIT_SLEEP_AFTER_IRQ 6
`define PCC_BIT_DRIVE_LOW_RANGE 0
`define PCC_BIT_WAIT_X12 1
`define PCC_FILTER_HI 7
`define PCC_FILTER_LO 4

// Writable bits; reserved positions read back as zero
`define PCC_MASK_FUNCTION_ENABLE 8'h6D
`define PCC_MASK_IRQ_PERSISTENCE 8'hF0
`define PCC_MASK_WAIT_DRIVE_OPTIONS 8'h03

`endif

// ===== pcc_pkg.sv
package pcc_pkg;

    typedef enum logic [5:0] {
        PCC_SLEEP = 6'h01,
        PCC_IDLE = 6'h02,
        PCC_PULSE = 6'h04,
        PCC_INTEG = 6'h08,
        PCC_EVAL = 6'h10,
        PCC_WAIT = 6'h20
    } pcc_state_e;

    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } pcc_reg_wr_s;

endpackage : pcc_pkg

// ===== pcc_cycle_control.sv
// Contract
// - With sleep-after-irq set, power down after a cycle that raised an interrupt.
// - Irq enable bit gates the flag onto the interrupt pin; flag stays visible.
// - Wait enable bit turns the wait timer between measurements on or off.
// - Proximity enable bit turns the measurement function on or off.
// - Oscillator-on bit starts the oscillator so timers and converter run.
// - Integration time counts in 2.73 ms steps; 0xFF is one step.
// - Integration time register resets to 0xFF.
// - Wait is 256 minus value steps of 2.73 ms; 0xFF one, 0x00 256.
// - Wait-x12 bit stretches the wait twelve times.
// - Compare result against 16-bit low and high thresholds, low byte first.
// - Persistence 0 interrupts every cycle; N needs N consecutive out-of-range results.
// - Drive-low-range bit reduces LED sink current to its low range.
// - Pulse count sets LED pulses emitted during each accumulation phase.
// - Interrupt flag is set whenever an interrupt is asserted, regardless of mask.
// - Pending interrupt holds until the interrupt clear function.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_cycle_control #(
    parameter int STEP_CYCLES = (`PCC_STEP_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS,
    parameter int LED_ON_CYCLES = (`PCC_LED_ON_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register access from the serial target
    input pcc_pkg::pcc_reg_wr_s reg_wr_i,
    input wire logic [4:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // Special functions
    input wire logic irq_set_i,
    input wire logic irq_clear_i,
    // Converter side
    input wire logic [15:0] prox_result_i,
    output logic osc_on_o,
    output logic integrating_o,
    output logic cycle_done_o,
    // LED driver
    output logic led_sink_pin_o,
    output logic drive_low_range_o,
    // Interrupt
    output logic prox_irq_flag_o,
    output logic int_n_o
);

    localparam int TMR_MAX = (STEP_CYCLES > 2 * LED_ON_CYCLES) ? STEP_CYCLES : 2 * LED_ON_CYCLES;
    localparam int TMR_W = $clog2(TMR_MAX + 1);

    if (STEP_CYCLES < 1 || LED_ON_CYCLES < 1) begin : g_bad_timing
        $error("pcc_cycle_control: step and LED times need at least one cycle");
    end

    // Steps for a two's complement count
    function automatic logic [8:0] pcc_steps(input logic [7:0] value);
        pcc_steps = `PCC_FULL_STEPS - {1'b0, value};
    endfunction : pcc_steps

    function automatic logic pcc_hit(input pcc_pkg::pcc_reg_wr_s wr, input logic [4:0] off);
        pcc_hit = wr.en && (wr.addr == off);
    endfunction : pcc_hit

    logic [7:0] function_enable;
    logic [7:0] integration_time;
    logic [7:0] wait_time;
    logic [7:0] low_threshold_lo;
    logic [7:0] low_threshold_hi;
    logic [7:0] high_threshold_lo;
    logic [7:0] high_threshold_hi;
    logic [7:0] irq_persistence;
    logic [7:0] wait_drive_options;
    logic [7:0] led_pulses;

    pcc_pkg::pcc_state_e state;
    pcc_pkg::pcc_state_e next_state;
    logic [TMR_W-1:0] tmr;
    logic [7:0] pulses_left;
    logic [8:0] steps_left;
    logic [3:0] mult_left;
    logic [3:0] oor_count;
    logic prox_irq_flag;

    logic oscillator_on;
    logic prox_function_enable;
    logic wait_enable;
    logic prox_irq_enable;
    logic sleep_after_irq;
    logic wait_x12;
    logic [3:0] out_of_range_filter;
    logic [15:0] low_threshold;
    logic [15:0] high_threshold;
    logic step_tick;
    logic pulse_done;
    logic pulses_finished;
    logic integ_done;
    logic wait_done;
    logic out_of_range;
    logic [4:0] oor_next;
    logic fire;
    logic [3:0] mult_reload;

    assign oscillator_on = function_enable[`PCC_BIT_OSCILLATOR_ON];
    assign prox_function_enable = function_enable[`PCC_BIT_PROX_FUNCTION_ENABLE];
    assign wait_enable = function_enable[`PCC_BIT_WAIT_ENABLE];
    assign prox_irq_enable = function_enable[`PCC_BIT_PROX_IRQ_ENABLE];
    assign sleep_after_irq = function_enable[`PCC_BIT_SLEEP_AFTER_IRQ];
    assign wait_x12 = wait_drive_options[`PCC_BIT_WAIT_X12];
    assign out_of_range_filter = irq_persistence[`PCC_FILTER_HI:`PCC_FILTER_LO];
    assign low_threshold = {low_threshold_hi, low_threshold_lo};
    assign high_threshold = {high_threshold_hi, high_threshold_lo};

    // Shared timer paces both the LED pulses and the 2.73 ms steps
    assign step_tick = (state == pcc_pkg::PCC_INTEG || state == pcc_pkg::PCC_WAIT)
        && (tmr == TMR_W'(STEP_CYCLES - 1));
    assign pulse_done = (state == pcc_pkg::PCC_PULSE) && (tmr == TMR_W'(2 * LED_ON_CYCLES - 1));
    assign pulses_finished = (pulses_left == 8'h00) || (pulse_done && pulses_left == 8'h01);
    assign integ_done = step_tick && (steps_left == 9'h001);
    assign mult_reload = wait_x12 ? 4'(`PCC_WAIT_LONG_FACTOR - 1) : 4'h0;
    assign wait_done = step_tick && (mult_left == 4'h0) && (steps_left == 9'h001);

    assign out_of_range = (prox_result_i < low_threshold) || (prox_result_i > high_threshold);
    assign oor_next = {1'b0, oor_count} + 5'h01;
    assign fire = (state == pcc_pkg::PCC_EVAL)
        && ((out_of_range_filter == 4'h0)
        || (out_of_range && oor_next >= {1'b0, out_of_range_filter}));

    always_comb begin
        next_state = state;
        if (!oscillator_on) begin
            next_state = pcc_pkg::PCC_SLEEP;
        end else if (!prox_function_enable) begin
            next_state = pcc_pkg::PCC_IDLE;
        end else begin
            unique case (state)
                pcc_pkg::PCC_SLEEP, pcc_pkg::PCC_IDLE: begin
                    next_state = pcc_pkg::PCC_PULSE;
                end
                pcc_pkg::PCC_PULSE: begin
                    if (pulses_finished) begin
                        next_state = pcc_pkg::PCC_INTEG;
                    end
                end
                pcc_pkg::PCC_INTEG: begin
                    if (integ_done) begin
                        next_state = pcc_pkg::PCC_EVAL;
                    end
                end
                pcc_pkg::PCC_EVAL: begin
                    if (fire && sleep_after_irq) begin
                        next_state = pcc_pkg::PCC_SLEEP;
                    end else if (wait_enable) begin
                        next_state = pcc_pkg::PCC_WAIT;
                    end else begin
                        next_state = pcc_pkg::PCC_PULSE;
                    end
                end
                pcc_pkg::PCC_WAIT: begin
                    if (wait_done) begin
                        next_state = pcc_pkg::PCC_PULSE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= pcc_pkg::PCC_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // Timer restarts on every state change
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || next_state != state || step_tick || pulse_done) begin
            tmr <= '0;
        end else begin
            tmr <= tmr + TMR_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pulses_left <= 8'h00;
        end else if (next_state == pcc_pkg::PCC_PULSE && state != pcc_pkg::PCC_PULSE) begin
            pulses_left <= led_pulses;
        end else if (pulse_done && pulses_left != 8'h00) begin
            pulses_left <= pulses_left - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            steps_left <= 9'h000;
            mult_left <= 4'h0;
        end else if (next_state == pcc_pkg::PCC_INTEG && state != pcc_pkg::PCC_INTEG) begin
            steps_left <= pcc_steps(integration_time);
            mult_left <= 4'h0;
        end else if (next_state == pcc_pkg::PCC_WAIT && state != pcc_pkg::PCC_WAIT) begin
            steps_left <= pcc_steps(wait_time);
            mult_left <= mult_reload;
        end else if (step_tick) begin
            if (state == pcc_pkg::PCC_WAIT && mult_left != 4'h0) begin
                mult_left <= mult_left - 4'h1;
            end else begin
                steps_left <= steps_left - 9'h001;
                mult_left <= (state == pcc_pkg::PCC_WAIT) ? mult_reload : 4'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !prox_function_enable) begin
            oor_count <= 4'h0;
        end else if (state == pcc_pkg::PCC_EVAL) begin
            if (!out_of_range) begin
                oor_count <= 4'h0;
            end else if (oor_count != 4'hF) begin
                oor_count <= oor_next[3:0];
            end
        end
    end

    // held until clear function, set wins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prox_irq_flag <= 1'b0;
        end else if (fire || irq_set_i) begin
            prox_irq_flag <= 1'b1;
        end else if (irq_clear_i) begin
            prox_irq_flag <= 1'b0;
        end
    end

    // Enable register; sleep-after-irq drops power, a host write wins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            function_enable <= `PCC_RST_FUNCTION_ENABLE;
        end else if (pcc_hit(reg_wr_i, `PCC_OFF_FUNCTION_ENABLE)) begin
            function_enable <= reg_wr_i.data & `PCC_MASK_FUNCTION_ENABLE;
        end else if (fire && sleep_after_irq) begin
            function_enable[`PCC_BIT_OSCILLATOR_ON] <= 1'b0;
        end
    end

    // Timing and LED configuration
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            integration_time <= `PCC_RST_INTEGRATION_TIME;
            wait_time <= `PCC_RST_WAIT_TIME;
            wait_drive_options <= `PCC_RST_WAIT_DRIVE_OPTIONS;
            led_pulses <= `PCC_RST_LED_PULSE_COUNT;
        end else begin
            if (pcc_hit(reg_wr_i, `PCC_OFF_INTEGRATION_TIME)) begin
                integration_time <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_WAIT_TIME)) begin
                wait_time <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_WAIT_DRIVE_OPTIONS)) begin
                wait_drive_options <= reg_wr_i.data & `PCC_MASK_WAIT_DRIVE_OPTIONS;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_LED_PULSE_COUNT)) begin
                led_pulses <= reg_wr_i.data;
            end
        end
    end

    // Thresholds and persistence
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            low_threshold_lo <= `PCC_RST_THRESHOLD;
            low_threshold_hi <= `PCC_RST_THRESHOLD;
            high_threshold_lo <= `PCC_RST_THRESHOLD;
            high_threshold_hi <= `PCC_RST_THRESHOLD;
            irq_persistence <= `PCC_RST_IRQ_PERSISTENCE;
        end else begin
            if (pcc_hit(reg_wr_i, `PCC_OFF_LOW_THRESHOLD_LO)) begin
                low_threshold_lo <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_LOW_THRESHOLD_HI)) begin
                low_threshold_hi <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_HIGH_THRESHOLD_LO)) begin
                high_threshold_lo <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_HIGH_THRESHOLD_HI)) begin
                high_threshold_hi <= reg_wr_i.data;
            end
            if (pcc_hit(reg_wr_i, `PCC_OFF_IRQ_PERSISTENCE)) begin
                irq_persistence <= reg_wr_i.data & `PCC_MASK_IRQ_PERSISTENCE;
            end
        end
    end

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            unique case (rd_addr_i)
                `PCC_OFF_FUNCTION_ENABLE: rd_data_o <= function_enable;
                `PCC_OFF_INTEGRATION_TIME: rd_data_o <= integration_time;
                `PCC_OFF_WAIT_TIME: rd_data_o <= wait_time;
                `PCC_OFF_LOW_THRESHOLD_LO: rd_data_o <= low_threshold_lo;
                `PCC_OFF_LOW_THRESHOLD_HI: rd_data_o <= low_threshold_hi;
                `PCC_OFF_HIGH_THRESHOLD_LO: rd_data_o <= high_threshold_lo;
                `PCC_OFF_HIGH_THRESHOLD_HI: rd_data_o <= high_threshold_hi;
                `PCC_OFF_IRQ_PERSISTENCE: rd_data_o <= irq_persistence;
                `PCC_OFF_WAIT_DRIVE_OPTIONS: rd_data_o <= wait_drive_options;
                `PCC_OFF_LED_PULSE_COUNT: rd_data_o <= led_pulses;
                default: rd_data_o <= 8'h00;
            endcase
        end
    end

    // Outputs from flops; LED lags the timer by one cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            led_sink_pin_o <= 1'b0;
            integrating_o <= 1'b0;
            cycle_done_o <= 1'b0;
            drive_low_range_o <= 1'b0;
            osc_on_o <= 1'b0;
            int_n_o <= 1'b1;
        end else begin
            // LED on for first half of each pulse slot
            led_sink_pin_o <= (state == pcc_pkg::PCC_PULSE) && (pulses_left != 8'h00)
                && (tmr < TMR_W'(LED_ON_CYCLES));
            integrating_o <= (state == pcc_pkg::PCC_INTEG);
            cycle_done_o <= (state == pcc_pkg::PCC_EVAL);
            drive_low_range_o <= wait_drive_options[`PCC_BIT_DRIVE_LOW_RANGE];
            osc_on_o <= oscillator_on;
            int_n_o <= !(prox_irq_flag && prox_irq_enable);
        end
    end

    assign prox_irq_flag_o = prox_irq_flag;

endmodule : pcc_cycle_control

// ===== pcc_chk.sv
`timescale 1ns/1ps
module pcc_chk #(
    parameter int STEP_CYCLES = 4,
    parameter int LED_ON_CYCLES = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Requests
    input pcc_pkg::pcc_reg_wr_s reg_wr_i,
    input wire logic irq_set_i,
    input wire logic irq_clear_i,
    // Observed outputs
    input wire logic osc_on_o,
    input wire logic integrating_o,
    input wire logic cycle_done_o,
    input wire logic led_sink_pin_o,
    input wire logic drive_low_range_o,
    input wire logic prox_irq_flag_o,
    input wire logic int_n_o
);
    logic [7:0] led_run;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Length of the current LED high phase
    always_ff @(posedge clk_i) begin
        led_run <= (!reset_n_i || !led_sink_pin_o) ? 8'h00 : led_run + 8'h01;
    end

    chk_osc_stop:
    assert property (reg_wr_i.en && reg_wr_i.addr == 5'h00 && !reg_wr_i.data[0]
        |-> ##2 !osc_on_o) else $error("oscillator left running");
    chk_pin_mask:
    assert property (!int_n_o |-> $past(prox_irq_flag_o))
        else $error("interrupt pin low without flag");
    chk_set_flag:
    assert property (irq_set_i |=> prox_irq_flag_o) else $error("forced interrupt not flagged");
    chk_flag_hold:
    assert property (prox_irq_flag_o && !irq_clear_i |=> prox_irq_flag_o)
        else $error("flag dropped without clear");
    chk_flag_clear:
    assert property (irq_clear_i && !irq_set_i && !osc_on_o |=> !prox_irq_flag_o)
        else $error("flag survived clear");
    chk_integ_len:
    assert property (cycle_done_o |-> $past(integrating_o) && $past(integrating_o, STEP_CYCLES)
        && !$past(integrating_o, STEP_CYCLES + 1)) else $error("integration length wrong");
    chk_led_width:
    assert property ($fell(led_sink_pin_o) |-> led_run == LED_ON_CYCLES)
        else $error("LED pulse width wrong");
    chk_drive_copy:
    assert property (reg_wr_i.en && reg_wr_i.addr == 5'h0D
        |-> ##2 drive_low_range_o == $past(reg_wr_i.data[0], 2))
        else $error("drive range not following register");
endmodule : pcc_chk

bind pcc_cycle_control pcc_chk #(
    .STEP_CYCLES(STEP_CYCLES),
    .LED_ON_CYCLES(LED_ON_CYCLES)
) u_pcc_chk (
    .clk_i, .reset_n_i, .reg_wr_i, .irq_set_i, .irq_clear_i, .osc_on_o, .integrating_o,
    .cycle_done_o, .led_sink_pin_o, .drive_low_range_o, .prox_irq_flag_o, .int_n_o
);

// ===== pcc_host_model.sv
`timescale 1ns/1ps
module pcc_host_model (
    // Clock
    input wire logic clk_i,
    // Requests toward the block
    output pcc_pkg::pcc_reg_wr_s reg_wr_o,
    output logic irq_set_o,
    output logic irq_clear_o
);
    initial begin
        reg_wr_o = '0;
        irq_set_o = 1'b0;
        irq_clear_o = 1'b0;
    end

    // Released bus shows inverted leftovers, never the last value
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_o <= {1'b1, a, d};
        @(posedge clk_i);
        reg_wr_o <= {1'b0, ~a, ~d};
    endtask : wr

    task automatic sf(input logic set);
        @(posedge clk_i);
        irq_set_o <= set;
        irq_clear_o <= !set;
        @(posedge clk_i);
        irq_set_o <= 1'b0;
        irq_clear_o <= 1'b0;
    endtask : sf

    // one step, enable last, callers keep reserved zero
    task automatic start(input logic [7:0] en, wt, cfg, np);
        wr(5'h02, 8'hFF);
        wr(5'h03, wt);
        wr(5'h0D, cfg);
        wr(5'h0E, np);
        wr(5'h00, en);
    endtask : start
endmodule : pcc_host_model

// ===== tb_pcc_cycle_control.sv
`timescale 1ns/1ps
module tb_pcc_cycle_control;
    localparam int STEP = 4;
    localparam int LED = 2;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    pcc_pkg::pcc_reg_wr_s reg_wr_i;
    logic [4:0] rd_addr_i = 5'h00;
    logic [15:0] prox_result_i = 16'h0000;
    logic irq_set_i, irq_clear_i, osc_on_o, integrating_o, cycle_done_o;
    logic led_sink_pin_o, drive_low_range_o, prox_irq_flag_o, int_n_o;
    logic [7:0] rd_data_o, v;
    logic ledp = 1'b0;
    logic rd_vld = 1'b0;
    logic rd_vld_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [4:0] ra [12] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
        5'h0D, 5'h0E, 5'h01, 5'h1F};
    logic [7:0] te [4] = '{8'h0D, 8'h0D, 8'h05, 8'h0D};
    logic [7:0] tw [4] = '{8'hFE, 8'hFE, 8'hFE, 8'h00};
    logic [7:0] tc [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
    logic [7:0] tp [4] = '{8'h03, 8'h03, 8'h00, 8'h01};
    // Values equal to a threshold count as in range
    logic [15:0] res [7] = '{16'h0201, 16'h00FF, 16'h0100, 16'h0200, 16'hFFFF,
        16'h0000, 16'h0201};
    int err_total = 0;
    int total_checks = 0;
    int seed = 98;
    int n;
    // Four-state so an unknown output cannot count as zero
    logic [15:0] k;

    always #50 clk_i = ~clk_i;

    pcc_cycle_control #(.STEP_CYCLES(STEP), .LED_ON_CYCLES(LED)) u_pcc_cycle_control (
        .clk_i, .reset_n_i, .reg_wr_i, .rd_addr_i, .rd_data_o, .irq_set_i, .irq_clear_i,
        .prox_result_i, .osc_on_o, .integrating_o, .cycle_done_o, .led_sink_pin_o,
        .drive_low_range_o, .prox_irq_flag_o, .int_n_o);
    pcc_host_model u_pcc_host_model (.clk_i, .reg_wr_o(reg_wr_i), .irq_set_o(irq_set_i),
        .irq_clear_o(irq_clear_i));

    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic conclude();
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    function automatic logic [7:0] msk(input logic [4:0] a);
        case (a)
            5'h00: return 8'h6D;
            5'h0C: return 8'hF0;
            5'h0D: return 8'h03;
            5'h01, 5'h1F: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction : msk

    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_addr_i <= a;
        rd_vld <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_vld <= 1'b0;
    endtask : rd

    // Read data lands one cycle after the address is taken
    always @(posedge clk_i) begin
        rd_vld_d <= rd_vld;
        if (rd_vld_d) chk("rd_data_o", exp_q.pop_front(), rd_data_o);
    end

    task automatic wait_on(input bit integ, input int lim);
        n = 0;
        do begin
            tick(1);
            n++;
            if (led_sink_pin_o && !ledp) k++;
            ledp = led_sink_pin_o;
            if (n > lim) begin
                chk("timeout", 16'h0000, 16'h0001);
                conclude();
            end
        end while ((integ ? integrating_o : cycle_done_o) !== 1'b1);
    endtask : wait_on

    // Stop inside integration so no LED pulse is cut short
    task automatic halt();
        wait_on(1'b1, 2000);
        u_pcc_host_model.wr(5'h00, 8'h00);
    endtask : halt

    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (ra[i]) rd(ra[i], (ra[i] inside {5'h02, 5'h03}) ? 8'hFF : 8'h00);
        foreach (ra[i]) begin
            v = 8'($random(seed));
            if (ra[i] == 5'h00) v = v & 8'h92;
            u_pcc_host_model.wr(ra[i], v);
            rd(ra[i], v & msk(ra[i]));
        end
        foreach (te[i]) begin
            u_pcc_host_model.start(te[i], tw[i], tc[i], tp[i]);
            wait_on(1'b0, 2000);
            k = 0;
            wait_on(1'b0, 2000);
            chk("period", (tp[i] ? tp[i] * 2 * LED : 1) + STEP + 1
                + (te[i][3] ? (256 - tw[i]) * STEP * (tc[i][1] ? 12 : 1) : 0), n);
            chk("pulses", tp[i], k);
            chk("drive_low", tc[i][0], drive_low_range_o);
            halt();
        end
        u_pcc_host_model.wr(5'h00, 8'h01);
        k = 0;
        repeat (20) begin
            tick(1);
            k += cycle_done_o;
        end
        chk("idle_done", 0, k);
        chk("osc_on", 1, osc_on_o);
        u_pcc_host_model.wr(5'h08, 8'h00);
        u_pcc_host_model.wr(5'h09, 8'h01);
        u_pcc_host_model.wr(5'h0A, 8'h00);
        u_pcc_host_model.wr(5'h0B, 8'h02);
        u_pcc_host_model.wr(5'h0C, 8'h30);
        u_pcc_host_model.sf(1'b0);
        res[1] = 16'($random(seed)) & 16'h00FF;
        res[6] = 16'h0201 + (16'($random(seed)) & 16'h7FFF);
        prox_result_i <= res[0];
        u_pcc_host_model.start(8'h05, 8'hFF, 8'h00, 8'h00);
        for (int j = 0; j < 7; j++) begin
            wait_on(1'b0, 200);
            chk("flag", j == 6, prox_irq_flag_o);
            @(posedge clk_i);
            prox_result_i <= res[(j + 1) % 7];
        end
        tick(2);
        chk("int_n_masked", 1, int_n_o);
        u_pcc_host_model.wr(5'h00, 8'h25);
        tick(2);
        chk("int_n", 0, int_n_o);
        halt();
        u_pcc_host_model.sf(1'b0);
        tick(2);
        chk("flag_clr", 0, prox_irq_flag_o);
        u_pcc_host_model.wr(5'h0C, 8'h00);
        u_pcc_host_model.start(8'h65, 8'hFF, 8'h00, 8'h02);
        wait_on(1'b0, 200);
        tick(2);
        chk("osc_sai", 0, osc_on_o);
        chk("int_n_sai", 0, int_n_o);
        rd(5'h00, 8'h64);
        u_pcc_host_model.sf(1'b0);
        u_pcc_host_model.sf(1'b1);
        tick(1);
        chk("flag_set", 1, prox_irq_flag_o);
        chk("int_n_set", 0, int_n_o);
        u_pcc_host_model.start(8'h0D, 8'hFE, 8'h00, 8'h01);
        wait_on(1'b0, 200);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        tick(1);
        chk("osc_rst", 0, osc_on_o);
        rd(5'h00, 8'h00);
        rd(5'h02, 8'hFF);
        tick(3);
        conclude();
    end
endmodule : tb_pcc_cycle_control
